// ==== common/uart_stat_pkg.sv ====
// Register map, field positions and reset values of the UART status and modem block
package uart_stat_pkg;
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_HOLD = 6'h00;
    localparam logic [5:0] OFS_MCTL = 6'h04;
    localparam logic [5:0] OFS_LSTAT = 6'h08;
    localparam logic [5:0] OFS_MSTAT = 6'h0C;
    localparam logic [5:0] OFS_SCR = 6'h10;
    localparam logic [5:0] OFS_DIVL = 6'h14;
    localparam logic [5:0] OFS_DIVH = 6'h18;
    localparam logic [5:0] OFS_IDENT = 6'h1C;
    localparam logic [5:0] OFS_REV = 6'h20;
    localparam logic [5:0] OFS_EFEAT = 6'h24;
    // Modem control fields
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_OP1 = 2;
    localparam int MC_OP2 = 3;
    localparam int MC_LOOP = 4;
    localparam int MC_XANY = 5;
    localparam int MC_PRESC = 7;
    // Bits that only change while the enhanced enable is set
    localparam logic [7:0] MC_ENH_MASK = 8'hE4;
    // Enhanced feature fields
    localparam int EF_ENH = 4;
    localparam int EF_ACTS = 7;
    // Modem status level and delta slots: 0 CTS, 1 DSR, 2 RI, 3 CD
    localparam int MS_RI = 2;
    // Line status fields
    localparam int LS_DR = 0;
    localparam int LS_OE = 1;
    localparam int LS_PE = 2;
    localparam int LS_FE = 3;
    localparam int LS_BI = 4;
    localparam int LS_THRE = 5;
    localparam int LS_TEMT = 6;
    localparam int LS_FERR = 7;
    // Reset values
    localparam logic [7:0] MCTL_RST = 8'h00;
    localparam logic [7:0] SCR_RST = 8'hFF;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [7:0] EFEAT_RST = 8'h00;
    localparam logic [7:0] BRK_CHAR = 8'h00;
    // Baud chain
    localparam logic [1:0] PRESC_LAST = 2'h3;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam int SYNC_WARM = 3;
endpackage

// ==== rtl/uart_stat_regs.sv ====
// UART line and modem status, control, scratch, divisor and identity registers on Wishbone
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Xon-any: any received char except Xoff resumes halted transmitter; flow chars not stored then.
// - Prescaler bit clear feeds clock straight; set divides it by four first.
// - Data-ready reads one while the receive FIFO holds any character.
// - Char arriving at full FIFO sets overrun and is dropped; FIFO kept intact.
// - Parity and framing flags describe the character at the read position.
// - Break stores one break char; flag stays set until line idles.
// - Holding-empty sets when transmit FIFO empties, clears once it holds a byte.
// - Transmitter-empty only when FIFO and shifter are both empty.
// - FIFO error flag set while any stored byte carries an error.
// - CTS, DSR, CD deltas set on any change since last status read.
// - RI delta sets only on ring input low-to-high.
// - Auto CTS: CTS high halts transmit after current char; low resumes.
// - Normally status bits four to seven are inverted CTS, DSR, RI, CD.
// - Loopback: RTS, DTR, control bits two, three drive status bits four to seven.
// - Scratch register is read/write, resets to FF.
// - Bit rate is prescaled clock over sixteen over sixteen-bit divisor.
// - Two read-only registers give identity code and revision code.
// - Low four feature bits select single or dual char software flow control.
// - Loopback bit enters internal loopback; clearing returns normal operation.
module uart_stat_regs
    import uart_stat_pkg::*;
#(
    parameter int DEPTH = 16,
    // Arbitrary identity and revision values
    parameter logic [7:0] DEV_IDENT = 8'h5A,
    parameter logic [7:0] DEV_REV = 8'h02
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [ADDR_W-1:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic CTS_N,
    input wire logic DSR_N,
    input wire logic RI_N,
    input wire logic CD_N,
    output logic DTR_N,
    output logic RTS_N,
    output logic LOOPBACK,
    input wire logic RX_DONE,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_PERR,
    input wire logic RX_FERR,
    input wire logic RX_IS_XON,
    input wire logic RX_IS_XOFF,
    input wire logic RX_BREAK,
    input wire logic RX_IDLE,
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    input wire logic TX_READY,
    input wire logic TX_BUSY,
    output logic [3:0] SWFC_SEL,
    output logic BAUD_X16,
    output logic BIT_TICK
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = $clog2(DEPTH);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [CW-1:0] ONE = CW'(1);
    localparam logic [PW-1:0] PONE = PW'(1);

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic ack_q;
    logic [31:0] dat_q;
    logic [7:0] rdata;
    logic acc, wr, rd;
    logic [7:0] mctl_q, scr_q, efeat_q;
    logic [15:0] div_q;

    assign acc = CYC_I & STB_I & ~ack_q;
    assign wr = acc & WE_I & SEL_I[0];
    assign rd = acc & ~WE_I;
    assign ACK_O = ack_q;
    assign DAT_O = dat_q;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else if (CE) begin
            ack_q <= acc;
            if (rd) begin
                dat_q <= {24'h00_0000, rdata};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mctl_q <= MCTL_RST;
            scr_q <= SCR_RST;
            efeat_q <= EFEAT_RST;
            div_q <= DIV_RST;
        end else if (CE && wr) begin
            unique case (ADR_I)
                OFS_MCTL: begin
                    // Enhanced bits hold their value while the feature enable is low
                    if (efeat_q[EF_ENH]) begin
                        mctl_q <= DAT_I[7:0];
                    end else begin
                        mctl_q <= (mctl_q & MC_ENH_MASK) | (DAT_I[7:0] & ~MC_ENH_MASK);
                    end
                end
                OFS_SCR: scr_q <= DAT_I[7:0];
                OFS_DIVL: div_q[7:0] <= DAT_I[7:0];
                OFS_DIVH: div_q[15:8] <= DAT_I[7:0];
                OFS_EFEAT: efeat_q <= DAT_I[7:0];
                default: begin
                end
            endcase
        end
    end

    assign LOOPBACK = mctl_q[MC_LOOP];
    // Outputs park inactive during loopback so the far end sees nothing
    assign DTR_N = ~mctl_q[MC_DTR] | mctl_q[MC_LOOP];
    assign RTS_N = ~mctl_q[MC_RTS] | mctl_q[MC_LOOP];
    assign SWFC_SEL = efeat_q[3:0];

    ////////////////////////////////////////////////////////////////////////////
    // Modem inputs and status
    logic [3:0] pin_n, sync1_q, sync2_q, lvl, prev_q, delta_q, dset;
    logic [SYNC_WARM-1:0] warm_q;
    logic rd_msr;

    assign pin_n = {CD_N, RI_N, DSR_N, CTS_N};
    assign rd_msr = rd && ADR_I == OFS_MSTAT;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= 4'hF;
            sync2_q <= 4'hF;
        end else if (CE) begin
            sync1_q <= pin_n;
            sync2_q <= sync1_q;
        end
    end

    always_comb begin
        if (mctl_q[MC_LOOP]) begin
            lvl = {mctl_q[MC_OP2], mctl_q[MC_OP1], mctl_q[MC_DTR], mctl_q[MC_RTS]};
        end else begin
            lvl = ~sync2_q;
        end
    end

    // Deltas armed only once the synchronisers hold real pin levels
    assign dset = {lvl[3] ^ prev_q[3],
                   prev_q[MS_RI] & ~lvl[MS_RI],
                   lvl[1:0] ^ prev_q[1:0]} & {4{warm_q[SYNC_WARM-1]}};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            prev_q <= 4'h0;
            delta_q <= 4'h0;
            warm_q <= '0;
        end else if (CE) begin
            warm_q <= {warm_q[SYNC_WARM-2:0], 1'b1};
            prev_q <= lvl;
            // New change beats the read that clears
            delta_q <= (delta_q & ~{4{rd_msr}}) | dset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive FIFO: data, parity, framing, break
    logic [10:0] rx_mem [DEPTH];
    logic [PW-1:0] rx_wp_q, rx_rp_q;
    logic [CW-1:0] rx_cnt_q, err_cnt_q;
    logic rx_full, rx_ne, rx_flow, brk_push, rx_char, rx_in, rx_push, rx_pop;
    logic ovr_q, brk_hold_q, in_err, head_err;
    logic [10:0] rx_word, head;

    assign rx_full = rx_cnt_q == FULL;
    assign rx_ne = rx_cnt_q != '0;
    assign rx_flow = efeat_q[1:0] != 2'b00;
    assign brk_push = RX_BREAK & ~brk_hold_q;
    assign rx_char = RX_DONE & ~(rx_flow & (RX_IS_XON | RX_IS_XOFF));
    assign rx_in = brk_push | rx_char;
    assign rx_push = rx_in & ~rx_full;
    assign rx_pop = rd && ADR_I == OFS_HOLD && rx_ne;
    assign rx_word = brk_push ? {1'b1, 2'b00, BRK_CHAR} : {1'b0, RX_FERR, RX_PERR, RX_DATA};
    assign head = rx_mem[rx_rp_q];
    assign in_err = |rx_word[10:8];
    assign head_err = |head[10:8];

    always_ff @(posedge CLK) begin
        if (CE && rx_push) begin
            rx_mem[rx_wp_q] <= rx_word;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            rx_cnt_q <= '0;
            err_cnt_q <= '0;
        end else if (CE) begin
            if (rx_push) begin
                rx_wp_q <= rx_wp_q == PW'(DEPTH - 1) ? '0 : rx_wp_q + PONE;
            end
            if (rx_pop) begin
                rx_rp_q <= rx_rp_q == PW'(DEPTH - 1) ? '0 : rx_rp_q + PONE;
            end
            rx_cnt_q <= rx_cnt_q + (rx_push ? ONE : '0) - (rx_pop ? ONE : '0);
            err_cnt_q <= err_cnt_q + (rx_push && in_err ? ONE : '0)
                         - (rx_pop && head_err ? ONE : '0);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovr_q <= 1'b0;
            brk_hold_q <= 1'b0;
        end else if (CE) begin
            // Overrun set wins over the clearing status read
            ovr_q <= (ovr_q & ~(rd && ADR_I == OFS_LSTAT)) | (rx_in & rx_full);
            if (brk_push) begin
                brk_hold_q <= 1'b1;
            end else if (RX_IDLE) begin
                brk_hold_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit FIFO and flow control
    logic [7:0] tx_mem [DEPTH];
    logic [PW-1:0] tx_wp_q, tx_rp_q;
    logic [CW-1:0] tx_cnt_q;
    logic tx_push, tx_pop, tx_empty, xoff_q, cts_halt;

    assign tx_empty = tx_cnt_q == '0;
    assign tx_push = wr && ADR_I == OFS_HOLD && tx_cnt_q != FULL;
    // Gating only the next fetch lets the char in flight finish
    assign cts_halt = efeat_q[EF_ACTS] & ~lvl[0];
    assign TX_VALID = ~tx_empty & ~cts_halt & ~xoff_q;
    assign TX_DATA = tx_mem[tx_rp_q];
    assign tx_pop = TX_VALID & TX_READY;

    always_ff @(posedge CLK) begin
        if (CE && tx_push) begin
            tx_mem[tx_wp_q] <= DAT_I[7:0];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            tx_cnt_q <= '0;
        end else if (CE) begin
            if (tx_push) begin
                tx_wp_q <= tx_wp_q == PW'(DEPTH - 1) ? '0 : tx_wp_q + PONE;
            end
            if (tx_pop) begin
                tx_rp_q <= tx_rp_q == PW'(DEPTH - 1) ? '0 : tx_rp_q + PONE;
            end
            tx_cnt_q <= tx_cnt_q + (tx_push ? ONE : '0) - (tx_pop ? ONE : '0);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            xoff_q <= 1'b0;
        end else if (CE) begin
            if (RX_DONE && rx_flow && RX_IS_XOFF) begin
                xoff_q <= 1'b1;
            end else if (RX_DONE && (RX_IS_XON || mctl_q[MC_XANY])) begin
                xoff_q <= 1'b0;
            end else if (!rx_flow) begin
                xoff_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Baud chain
    logic [1:0] pre_q;
    logic [15:0] dcnt_q;
    logic [3:0] ovs_q;
    logic pre_tick, x16_q, bit_q;

    assign pre_tick = ~mctl_q[MC_PRESC] | (pre_q == PRESC_LAST);
    assign BAUD_X16 = x16_q;
    assign BIT_TICK = bit_q;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_q <= 2'h0;
            dcnt_q <= DIV_RST;
            x16_q <= 1'b0;
            ovs_q <= 4'h0;
            bit_q <= 1'b0;
        end else if (CE) begin
            pre_q <= mctl_q[MC_PRESC] ? pre_q + 2'h1 : 2'h0;
            x16_q <= 1'b0;
            bit_q <= 1'b0;
            if (pre_tick) begin
                // A zero divisor stops the generator
                if (dcnt_q <= 16'h0001) begin
                    dcnt_q <= div_q;
                    x16_q <= div_q != 16'h0000;
                end else begin
                    dcnt_q <= dcnt_q - 16'h0001;
                end
            end
            if (x16_q) begin
                ovs_q <= ovs_q + 4'h1;
                bit_q <= ovs_q == OVS_LAST;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    logic [7:0] lstat;

    assign lstat = {err_cnt_q != '0,
                    tx_empty & ~TX_BUSY,
                    tx_empty,
                    (rx_ne & head[10]) | brk_hold_q,
                    rx_ne & head[9], rx_ne & head[8],
                    ovr_q, rx_ne};

    always_comb begin
        unique case (ADR_I)
            OFS_HOLD: rdata = head[7:0];
            OFS_MCTL: rdata = mctl_q;
            OFS_LSTAT: rdata = lstat;
            OFS_MSTAT: rdata = {lvl, delta_q};
            OFS_SCR: rdata = scr_q;
            OFS_DIVL: rdata = div_q[7:0];
            OFS_DIVH: rdata = div_q[15:8];
            OFS_IDENT: rdata = DEV_IDENT;
            OFS_REV: rdata = DEV_REV;
            OFS_EFEAT: rdata = efeat_q;
            default: rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_ack_single: assert property (CE && ACK_O |=> !ACK_O) else $error("ack held two cycles");
    a_data_ready: assert property (CE && rx_push |=> lstat[LS_DR]) else $error("ready mismatch");
    a_overrun_drop: assert property (CE && rx_in && rx_full |=> ovr_q && $stable(rx_wp_q))
        else $error("overrun lost or stored");
    a_break_hold: assert property (CE && brk_push || brk_hold_q && !RX_IDLE |=> lstat[LS_BI])
        else $error("break dropped early");
    a_ri_edge: assert property (CE && warm_q[SYNC_WARM-1] && !rd_msr && $past(delta_q[MS_RI]) == 1'b0
        && delta_q[MS_RI] == 1'b0 |=> delta_q[MS_RI] == ($past(prev_q[MS_RI]) && !$past(lvl[MS_RI])))
        else $error("ring delta");
    a_loop_map: assert property (mctl_q[MC_LOOP] |-> lvl == {mctl_q[3:2], mctl_q[0], mctl_q[1]})
        else $error("loopback map");
    a_pin_map: assert property (!mctl_q[MC_LOOP] |-> lvl == ~sync2_q) else $error("pin map");
    a_cts_halt: assert property (efeat_q[EF_ACTS] && !lvl[0] |-> !TX_VALID) else $error("cts");
    a_temt_busy: assert property (TX_BUSY |-> !lstat[LS_TEMT]) else $error("temt while busy");
    a_ferr_sum: assert property (lstat[LS_FERR] |-> rx_ne) else $error("error flag empty");
    a_presc_four: assert property (CE && x16_q && mctl_q[MC_PRESC] && $stable(mctl_q) |-> !$past(x16_q))
        else $error("prescaled tick");
    a_delta_clear: assert property (CE && rd_msr && dset == 4'h0 |=> delta_q == 4'h0)
        else $error("delta not cleared");

    c_overrun: cover property (CE && rx_in && rx_full);
    c_break: cover property (CE && brk_push);
    c_xany: cover property (CE && xoff_q && RX_DONE && mctl_q[MC_XANY]);
    c_tx_drain: cover property (tx_pop && tx_cnt_q == ONE);
endmodule

// ==== test/serial_far_end.sv ====
// Remote terminal model: delivers received chars, drains the transmitter, drives modem lines
`timescale 1ns/1ps
module serial_far_end (
    input wire logic CLK,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    output logic TX_READY,
    output logic TX_BUSY,
    output logic RX_DONE,
    output logic [7:0] RX_DATA,
    output logic [3:0] RX_FLAGS,
    output logic RX_BREAK,
    output logic RX_IDLE,
    output logic [3:0] PINS_N
);
    logic [7:0] got[$];
    logic stall;
    int busy_n;
    initial begin
        RX_DONE = 1'b0;
        RX_DATA = 8'h00;
        RX_FLAGS = 4'h0;
        RX_BREAK = 1'b0;
        RX_IDLE = 1'b1;
        PINS_N = 4'hF;
        stall = 1'b0;
        busy_n = 0;
    end
    ////////////////////////////////
    // Slow line: nothing new is taken while a char is still shifting out
    assign TX_READY = !stall && busy_n == 0;
    assign TX_BUSY = busy_n != 0;
    always @(posedge CLK) begin
        if (TX_VALID && TX_READY) begin
            got.push_back(TX_DATA);
            busy_n <= 12;
        end else if (busy_n != 0) begin
            busy_n <= busy_n - 1;
        end
    end
    // Flags are {xoff, xon, framing, parity}
    task automatic send(input logic [7:0] d, input logic [3:0] f);
        @(posedge CLK);
        RX_DONE <= 1'b1;
        RX_DATA <= d;
        RX_FLAGS <= f;
        @(posedge CLK);
        RX_DONE <= 1'b0;
        // Stale data must not look valid
        RX_DATA <= ~d;
        RX_FLAGS <= 4'h0;
    endtask
    task automatic brk();
        @(posedge CLK);
        RX_BREAK <= 1'b1;
        RX_IDLE <= 1'b0;
        @(posedge CLK);
        RX_BREAK <= 1'b0;
    endtask
    task automatic ctl(input logic s, input logic i, input logic [3:0] p);
        @(posedge CLK);
        stall <= s;
        RX_IDLE <= i;
        PINS_N <= p;
    endtask
endmodule

// ==== test/tb_uart_status_modem_regs.sv ====
// Self-checking bench for the UART status, modem, scratch and divisor registers
`timescale 1ns/1ps
module tb_uart_status_modem_regs
    import uart_stat_pkg::*;
;
    // Arbitrary identity and revision values
    localparam logic [7:0] ID_CODE = 8'h3D;
    localparam logic [7:0] REV_CODE = 8'h07;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [3:0] sel = 4'h0;
    logic [7:0] dat = 8'h00;
    logic [7:0] rv, txd, rxd;
    logic [31:0] rdat;
    logic ack, dtr_n, rts_n, loop, txv, txr, txb, baud, tick, rxv, rbrk, ridle;
    logic [3:0] swfc, pins_n, rxf;
    int failures = 0;
    int num_checks = 0;
    always #12.5 clk = ~clk;
    uart_stat_regs #(.DEPTH(4), .DEV_IDENT(ID_CODE), .DEV_REV(REV_CODE)) dut_u (
        .CLK(clk), .RST_N(rst_n), .CE(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I({24'h000000, dat}), .DAT_O(rdat), .ACK_O(ack),
        .CTS_N(pins_n[0]), .DSR_N(pins_n[1]), .RI_N(pins_n[2]), .CD_N(pins_n[3]),
        .DTR_N(dtr_n), .RTS_N(rts_n), .LOOPBACK(loop), .RX_DONE(rxv), .RX_DATA(rxd),
        .RX_PERR(rxf[0]), .RX_FERR(rxf[1]), .RX_IS_XON(rxf[2]), .RX_IS_XOFF(rxf[3]),
        .RX_BREAK(rbrk), .RX_IDLE(ridle), .TX_VALID(txv), .TX_DATA(txd), .TX_READY(txr),
        .TX_BUSY(txb), .SWFC_SEL(swfc), .BAUD_X16(baud), .BIT_TICK(tick)
    );
    serial_far_end far (
        .CLK(clk), .TX_VALID(txv), .TX_DATA(txd), .TX_READY(txr), .TX_BUSY(txb), .RX_DONE(rxv),
        .RX_DATA(rxd), .RX_FLAGS(rxf), .RX_BREAK(rbrk), .RX_IDLE(ridle), .PINS_N(pins_n)
    );
    ////////////////////////////////
    task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Request held until ack is sampled; read data taken at that edge
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'h1;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100) failures++;
        rv = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e, input string n);
        wb(1'b0, a, 8'h00);
        chk(rv, e, n);
    endtask
    // Pin change plus synchroniser settling
    task automatic pin(input logic [3:0] p);
        far.ctl(1'b0, 1'b1, p);
        repeat (6) @(posedge clk);
    endtask
    task automatic wait_tx(input int k);
        for (int n = 0; n < 300 && far.got.size() < k; n++) @(posedge clk);
    endtask
    task automatic gap(input logic b, input int e, input string n);
        int c;
        repeat (20) @(posedge clk);
        for (c = 0; c < 1000 && (b ? tick : baud) !== 1'b1; c++) @(posedge clk);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while ((b ? tick : baud) !== 1'b1 && c < 1100);
        chk(16'(c), 16'(e), n);
    endtask
    ////////////////////////////////
    task automatic t_reset();
        rd(OFS_LSTAT, 8'h60, "lsr rst");
        rd(OFS_MSTAT, 8'h00, "msr rst");
        rd(OFS_MCTL, 8'h00, "mcr rst");
        rd(OFS_EFEAT, 8'h00, "efr rst");
        rd(OFS_DIVL, 8'h01, "divl rst");
        rd(OFS_DIVH, 8'h00, "divh rst");
        rd(OFS_SCR, 8'hFF, "scratch rst");
        wr(OFS_SCR, 8'hA5);
        rd(OFS_SCR, 8'hA5, "scratch rw");
    endtask
    task automatic t_modem();
        pin(4'hE);
        rd(OFS_MSTAT, 8'h11, "cts change");
        rd(OFS_MSTAT, 8'h10, "delta clear");
        pin(4'hA);
        rd(OFS_MSTAT, 8'h50, "ring start");
        pin(4'hE);
        rd(OFS_MSTAT, 8'h14, "ring end");
        pin(4'hF);
        rd(OFS_MSTAT, 8'h01, "cts release");
    endtask
    task automatic t_loop();
        wr(OFS_MCTL, 8'h1B);
        chk({5'h0, loop, dtr_n, rts_n}, 8'h07, "loop pins");
        wb(1'b0, OFS_MSTAT, 8'h00);
        chk(rv & 8'hF0, 8'hB0, "loop msr");
        wr(OFS_MCTL, 8'h03);
        chk({5'h0, loop, dtr_n, rts_n}, 8'h00, "normal pins");
        wr(OFS_MCTL, 8'h00);
        wb(1'b0, OFS_MSTAT, 8'h00);
    endtask
    task automatic t_rx();
        far.send(8'h3C, 4'h1);
        far.send(8'h5A, 4'h2);
        rd(OFS_LSTAT, 8'hE5, "parity head");
        rd(OFS_HOLD, 8'h3C, "first char");
        rd(OFS_LSTAT, 8'hE9, "framing head");
        rd(OFS_HOLD, 8'h5A, "second char");
        rd(OFS_LSTAT, 8'h60, "rx empty");
    endtask
    task automatic t_ovr();
        for (int i = 0; i < 5; i++) far.send(8'h10 + 8'(i), 4'h0);
        rd(OFS_LSTAT, 8'h63, "overrun");
        rd(OFS_LSTAT, 8'h61, "overrun read");
        for (int i = 0; i < 4; i++) rd(OFS_HOLD, 8'h10 + 8'(i), "fifo kept");
        rd(OFS_LSTAT, 8'h60, "drained");
    endtask
    task automatic t_brk();
        far.brk();
        wb(1'b0, OFS_LSTAT, 8'h00);
        chk(rv & 8'hF3, 8'hF1, "break in");
        rd(OFS_HOLD, BRK_CHAR, "break char");
        rd(OFS_LSTAT, 8'h70, "break held");
        far.ctl(1'b0, 1'b1, 4'hF);
        rd(OFS_LSTAT, 8'h60, "line idle");
    endtask
    task automatic t_tx();
        far.ctl(1'b1, 1'b1, 4'hF);
        wr(OFS_HOLD, 8'h96);
        rd(OFS_LSTAT, 8'h00, "tx queued");
        far.ctl(1'b0, 1'b1, 4'hF);
        wait_tx(1);
        rd(OFS_LSTAT, 8'h20, "tx shifting");
        repeat (20) @(posedge clk);
        rd(OFS_LSTAT, 8'h60, "tx idle");
        chk(far.got[0], 8'h96, "tx byte");
    endtask
    task automatic t_cts();
        wr(OFS_EFEAT, 8'h80);
        wr(OFS_HOLD, 8'h77);
        repeat (30) @(posedge clk);
        chk(16'(far.got.size()), 16'h1, "cts halt");
        pin(4'hE);
        wait_tx(2);
        chk(far.got[1], 8'h77, "cts resume");
        pin(4'hF);
        wr(OFS_EFEAT, 8'h00);
    endtask
    task automatic t_xany();
        wr(OFS_EFEAT, 8'h10);
        wr(OFS_MCTL, 8'h20);
        rd(OFS_MCTL, 8'h20, "xany bit");
        wr(OFS_EFEAT, 8'h00);
        wr(OFS_EFEAT, 8'h12);
        far.send(8'h13, 4'h8);
        wr(OFS_HOLD, 8'h55);
        repeat (30) @(posedge clk);
        chk(16'(far.got.size()), 16'h2, "xoff halt");
        far.send(8'h41, 4'h0);
        wait_tx(3);
        chk(far.got[2], 8'h55, "any resumes");
        rd(OFS_HOLD, 8'h41, "any stored");
        repeat (20) @(posedge clk);
        rd(OFS_LSTAT, 8'h60, "xoff dropped");
        for (int i = 0; i < 16; i++) begin
            wr(OFS_EFEAT, 8'h10);
            wr(OFS_EFEAT, 8'h10 | 8'(i));
            chk({4'h0, swfc}, 8'(i), "flow select");
        end
        wr(OFS_MCTL, 8'h00);
    endtask
    task automatic t_baud();
        wr(OFS_DIVL, 8'h03);
        wr(OFS_DIVH, 8'h00);
        gap(1'b0, 3, "x16 period");
        gap(1'b1, 48, "bit period");
        wr(OFS_MCTL, 8'h80);
        gap(1'b0, 12, "prescaled");
        wr(OFS_MCTL, 8'h00);
        wr(OFS_DIVH, 8'h01);
        gap(1'b0, 259, "wide divisor");
    endtask
    task automatic t_ident();
        wr(OFS_DIVL, 8'h00);
        wr(OFS_DIVH, 8'h00);
        wr(OFS_IDENT, 8'hFF);
        rd(OFS_IDENT, ID_CODE, "identity");
        rd(OFS_REV, REV_CODE, "revision");
        rd(6'h3C, 8'h00, "unmapped");
    endtask
    // Char strobed while frozen must be lost, so nothing is pending after
    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0;
        far.send(8'h66, 4'h0);
        @(posedge clk);
        ce <= 1'b1;
        rd(OFS_LSTAT, 8'h60, "frozen rx");
    endtask
    ////////////////////////////////
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_modem();
        t_loop();
        t_rx();
        t_ovr();
        t_brk();
        t_tx();
        t_cts();
        t_xany();
        t_baud();
        t_ident();
        t_freeze();
        complete_run();
    end
    // Whole run is under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run();
    end
endmodule
